// ==== include/vco_cal_pkg.sv ====
package vco_cal_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_REFDIV = 8'h02;
  localparam logic [7:0] IDX_INT = 8'h03;
  localparam logic [7:0] IDX_FRAC = 8'h04;
  localparam logic [7:0] IDX_FWD = 8'h05;
  localparam logic [7:0] IDX_LDCFG = 8'h07;
  localparam logic [7:0] IDX_CALCFG = 8'h0a;
  localparam logic [7:0] IDX_SWSTAT = 8'h10;
  localparam logic [7:0] IDX_CNTERR = 8'h11;
  // field positions
  localparam int RELOCK_BIT = 13;
  localparam int CALDIS_BIT = 11;
  localparam int NSEL_LO = 0;
  localparam int KSEL_LO = 6;
  localparam int MSEL_LO = 13;
  localparam int SW_LO = 8;
  localparam int RSVD_BIT = 13;
  localparam int ADDR_HI = 6;
  localparam int ID_W = 3;
  localparam int DATA_LO = 7;
  localparam int BUSY_BIT = 8;
  localparam int SKIP_BIT = 9;
  localparam int FRAC_BITS = 24;
  // widths
  localparam int REFDIV_W = 14;
  localparam int INT_W = 19;
  localparam int FRAC_W = 24;
  localparam int FWD_W = 16;
  localparam int CALCFG_W = 15;
  localparam int ERR_W = 20;
  localparam int CNT_W = 32;
  // reset values
  localparam logic [13:0] REFDIV_RST = 14'h0001;
  localparam logic [18:0] INT_RST = 19'h00000;
  localparam logic [23:0] FRAC_RST = 24'h000000;
  localparam logic [15:0] FWD_RST = 16'h0000;
  localparam logic [14:0] CALCFG_RST = 15'h0000;
  localparam logic [5:0] OUTDIV_RST = 6'h01;
  // serial link and timing
  localparam logic [3:0] OUTDIV_REG = 4'h2;
  localparam logic [5:0] OUTDIV_MAX = 6'h3e;
  localparam logic [4:0] XFER_CYC = 5'h14;
  localparam logic [4:0] XFER_BITS = 5'h10;
  localparam logic [8:0] WAIT_UNIT = 9'h080;
  typedef enum logic [2:0] {S_IDLE, S_XFER, S_WAIT, S_MEAS, S_FINAL} cal_state_t;
endpackage

// ==== design/vco_cal_fsm.sv ====
// Functional notes
// - fundamental or even divide 2..62 selectable
// - new frequency selects switch setting automatically
// - host may write forwarding register directly
// - hold tuning midpoint, count, search switch
// - calibration keeps target id and address
// - auto relock on lock loss, once
// - calibration enabled starts on frequency change
// - rewriting same frequency reruns calibration
// - window is reference times R times 2^n
// - codes 0-3 direct, 4-7 give 5..8
// - expected count floor of N times 2^n
// - calibration clock reference over 1/4/16/32
// - calibration clock drives the serial link
// - serial transfer takes twenty calibration clock cycles
// - k times 128 wait cycles before measuring
// - divider released only after final switch
// - calibration can be disabled for manual tuning
// - forwarding write shifts 16 bits msb first
// - calibration only with low seven bits zero
// - selected switch readable in status field
`timescale 1ns/1ps
`default_nettype none
module vco_cal_fsm
  import vco_cal_pkg::*;
#(
  parameter int SW_W = 5
)(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic HREADYOUT_O,
  output logic [31:0] HRDATA_O,
  output logic HRESP_O,
  input wire logic REF_TICK_I,
  input wire logic VCO_TICK_I,
  input wire logic LOCK_I,
  output logic VSL_SEN_N_O,
  output logic VSL_SCK_O,
  output logic VSL_SDO_O,
  output logic VTUNE_HOLD_O,
  output logic MOD_LOAD_O,
  output logic [18:0] MOD_INT_O,
  output logic [23:0] MOD_FRAC_O,
  output logic [5:0] OUT_DIV_O,
  output logic CAL_BUSY_O
);

  function automatic logic [3:0] n_of(input logic [2:0] code);
    n_of = (code < 3'h4) ? {1'b0, code} : ({1'b0, code} + 4'h1);
  endfunction

  function automatic logic [5:0] caldiv_of(input logic [1:0] m);
    case (m)
      2'h0: caldiv_of = 6'h01;
      2'h1: caldiv_of = 6'h04;
      2'h2: caldiv_of = 6'h10;
      default: caldiv_of = 6'h20;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] expect_of(input logic [18:0] ni, input logic [23:0] nf,
                                                 input logic [3:0] n);
    logic [50:0] full;
    full = {8'h00, ni, nf} << n;
    expect_of = {5'h00, full[50:FRAC_BITS]};
  endfunction

  // bus and register state
  logic hwr_r, hwr_nxt, relock_en_r, relock_en_nxt, skip_r, skip_nxt;
  logic [7:0] hidx_r, hidx_nxt;
  logic [31:0] hrdata_r, hrdata_nxt, rd_mux;
  logic [13:0] refdiv_r, refdiv_nxt;
  logic [18:0] int_r, int_nxt, mint_r, mint_nxt;
  logic [23:0] frac_r, frac_nxt, mfrac_r, mfrac_nxt;
  logic [15:0] fwd_r, fwd_nxt, sh_r, sh_nxt, cal_word;
  logic [14:0] calcfg_r, calcfg_nxt;
  logic [ERR_W-1:0] err_r, err_nxt;
  // calibration state
  cal_state_t st_r, st_nxt;
  logic [5:0] cdiv_r, cdiv_nxt, odiv_r, odiv_nxt, div_req;
  logic [SW_W-1:0] sw_r, sw_nxt, bit_r, bit_nxt;
  logic [8:0] wait_r, wait_nxt;
  logic [21:0] win_r, win_nxt, win_len;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, exp_cnt, diff;
  logic relock_used_r, relock_used_nxt, lock_d_r, lock_d_nxt, resend_r, resend_nxt;
  // serial link state
  logic [4:0] bc_r, bc_nxt;
  logic xfer_r, xfer_nxt, sen_n_r, sen_n_nxt, sck_r, sck_nxt, sck_arm_r, sck_arm_nxt;
  logic sdo_r, sdo_nxt, hold_r, hold_nxt, load_r, load_nxt;
  logic cal_tick, freq_wr, fwd_wr, start;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (HADDR_I[9:2])
      IDX_REFDIV: rd_mux = {18'h00000, refdiv_r};
      IDX_INT: rd_mux = {13'h0000, int_r};
      IDX_FRAC: rd_mux = {8'h00, frac_r};
      IDX_FWD: rd_mux = {16'h0000, fwd_r};
      IDX_LDCFG: rd_mux = {18'h00000, relock_en_r, 13'h0000};
      IDX_CALCFG: rd_mux = {17'h00000, calcfg_r};
      IDX_SWSTAT: rd_mux = {22'h000000, skip_r, st_r != S_IDLE, fwd_r[15:DATA_LO+1]};
      IDX_CNTERR: rd_mux = {12'h000, err_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    hwr_nxt = HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
    hidx_nxt = HADDR_I[9:2];
    hrdata_nxt = (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I) ? rd_mux : hrdata_r;
    refdiv_nxt = refdiv_r;
    int_nxt = int_r;
    frac_nxt = frac_r;
    fwd_nxt = fwd_r;
    relock_en_nxt = relock_en_r;
    calcfg_nxt = calcfg_r;
    freq_wr = 1'b0;
    fwd_wr = 1'b0;
    if (hwr_r)
    begin
      case (hidx_r)
        IDX_REFDIV: refdiv_nxt = HWDATA_I[REFDIV_W-1:0];
        IDX_INT: int_nxt = HWDATA_I[INT_W-1:0];
        IDX_FRAC: frac_nxt = HWDATA_I[FRAC_W-1:0];
        IDX_FWD: fwd_nxt = HWDATA_I[FWD_W-1:0];
        IDX_LDCFG: relock_en_nxt = HWDATA_I[RELOCK_BIT];
        IDX_CALCFG: calcfg_nxt = HWDATA_I[CALCFG_W-1:0];
        default: ;
      endcase
      // identical rewrite still counts as a request
      freq_wr = (hidx_r == IDX_INT) || (hidx_r == IDX_FRAC);
      fwd_wr = (hidx_r == IDX_FWD);
    end
    // >= so that a smaller divider chosen mid-count does not wait for a wrap
    cal_tick = REF_TICK_I && (cdiv_r >= caldiv_of(calcfg_r[MSEL_LO+1:MSEL_LO]) - 6'h01);
    cdiv_nxt = REF_TICK_I ? (cal_tick ? 6'h00 : cdiv_r + 6'h01) : cdiv_r;
    win_len = 22'({8'h00, refdiv_r} << n_of(calcfg_r[NSEL_LO+2:NSEL_LO]));
    exp_cnt = expect_of(int_r, frac_r, n_of(calcfg_r[NSEL_LO+2:NSEL_LO]));
    diff = cnt_r - exp_cnt;
    // calibration drives the switch bits and sets bit 13; id and address stay
    cal_word = {fwd_r[15:14], 1'b1, sw_r, fwd_r[7:0]};
    lock_d_nxt = LOCK_I;
    relock_used_nxt = freq_wr ? 1'b0 : relock_used_r;
    start = 1'b0;
    if (freq_wr && !calcfg_r[CALDIS_BIT])
      start = 1'b1;
    else if (relock_en_r && lock_d_r && !LOCK_I && !relock_used_r && st_r == S_IDLE)
    begin
      start = 1'b1;
      relock_used_nxt = 1'b1;
    end
    st_nxt = st_r;
    sw_nxt = sw_r;
    bit_nxt = bit_r;
    wait_nxt = wait_r;
    win_nxt = win_r;
    cnt_nxt = cnt_r;
    err_nxt = err_r;
    skip_nxt = skip_r;
    sh_nxt = sh_r;
    bc_nxt = bc_r;
    xfer_nxt = xfer_r;
    sen_n_nxt = sen_n_r;
    sck_nxt = sck_arm_r;
    sck_arm_nxt = 1'b0;
    resend_nxt = resend_r;
    sdo_nxt = sdo_r;
    load_nxt = 1'b0;
    mint_nxt = mint_r;
    mfrac_nxt = mfrac_r;
    odiv_nxt = odiv_r;
    // serial engine: twenty calibration cycles per word, sixteen carry data
    if (xfer_r && cal_tick)
    begin
      if (bc_r < XFER_BITS)
      begin
        sen_n_nxt = 1'b0;
        sdo_nxt = sh_r[15];
        sh_nxt = {sh_r[14:0], 1'b0};
        sck_arm_nxt = 1'b1;
      end
      else
      begin
        sen_n_nxt = 1'b1;
        sdo_nxt = 1'b0;
      end
      bc_nxt = bc_r + 5'h01;
      if (bc_r == XFER_CYC - 5'h01)
        xfer_nxt = 1'b0;
    end
    if (fwd_wr && st_r == S_IDLE)
    begin
      sh_nxt = HWDATA_I[15:0];
      bc_nxt = 5'h00;
      xfer_nxt = 1'b1;
      div_req = HWDATA_I[DATA_LO+5:DATA_LO];
      if (HWDATA_I[ADDR_HI:0] == {OUTDIV_REG, 3'h0} &&
          (div_req == 6'h01 || (!div_req[0] && div_req != 6'h00 && div_req <= OUTDIV_MAX)))
        odiv_nxt = div_req;
    end
    else
      div_req = 6'h00;
    case (st_r)
      S_IDLE: ;
      S_XFER:
        if (!xfer_r && resend_r)
        begin
          sh_nxt = cal_word;
          bc_nxt = 5'h00;
          xfer_nxt = 1'b1;
          resend_nxt = 1'b0;
        end
        else if (!xfer_r)
        begin
          st_nxt = S_WAIT;
          wait_nxt = 9'({7'h00, calcfg_r[KSEL_LO+1:KSEL_LO]} * WAIT_UNIT);
        end
      S_WAIT:
        if (wait_r == 9'h000)
        begin
          st_nxt = S_MEAS;
          win_nxt = win_len;
          cnt_nxt = '0;
        end
        else if (cal_tick)
          wait_nxt = wait_r - 9'h001;
      S_MEAS:
      begin
        if (VCO_TICK_I)
          cnt_nxt = cnt_r + 32'h0000_0001;
        if (REF_TICK_I)
          win_nxt = win_r - 22'h000001;
        if (REF_TICK_I && win_r == 22'h000001)
        begin
          err_nxt = diff[ERR_W-1:0];
          // too fast keeps more capacitance switched in
          if (cnt_r <= exp_cnt)
            sw_nxt = sw_r & ~bit_r;
          if (bit_r[0])
          begin
            sh_nxt = {fwd_r[15:14], 1'b1, (cnt_r <= exp_cnt) ? (sw_r & ~bit_r) : sw_r, fwd_r[7:0]};
            st_nxt = S_FINAL;
          end
          else
          begin
            sw_nxt = ((cnt_r <= exp_cnt) ? (sw_r & ~bit_r) : sw_r) | (bit_r >> 1);
            bit_nxt = bit_r >> 1;
            sh_nxt = {fwd_r[15:14], 1'b1, ((cnt_r <= exp_cnt) ? (sw_r & ~bit_r) : sw_r)
                      | (bit_r >> 1), fwd_r[7:0]};
            st_nxt = S_XFER;
          end
          bc_nxt = 5'h00;
          xfer_nxt = 1'b1;
        end
      end
      S_FINAL:
        if (!xfer_r)
        begin
          st_nxt = S_IDLE;
          fwd_nxt[SW_LO+SW_W-1:SW_LO] = sw_r;
          fwd_nxt[RSVD_BIT] = 1'b1;
          load_nxt = 1'b1;
          mint_nxt = int_r;
          mfrac_nxt = frac_r;
        end
      default: st_nxt = S_IDLE;
    endcase
    if (start)
    begin
      if (fwd_r[ADDR_HI:0] != 7'h00)
      begin
        skip_nxt = 1'b1;
        resend_nxt = 1'b0;
        st_nxt = S_IDLE;
        load_nxt = 1'b1;
        mint_nxt = int_nxt;
        mfrac_nxt = frac_nxt;
      end
      else
      begin
        // restart from the top with the newest divider
        skip_nxt = 1'b0;
        st_nxt = S_XFER;
        bit_nxt = SW_W'(1) << (SW_W - 1);
        sw_nxt = SW_W'(1) << (SW_W - 1);
        // a frame already on the link is finished first; the first word follows it
        resend_nxt = xfer_r;
        if (!xfer_r)
        begin
          sh_nxt = {fwd_r[15:14], 1'b1, SW_W'(1) << (SW_W - 1), fwd_r[7:0]};
          bc_nxt = 5'h00;
          xfer_nxt = 1'b1;
        end
      end
    end
    else if (freq_wr)
    begin
      load_nxt = 1'b1;
      mint_nxt = int_nxt;
      mfrac_nxt = frac_nxt;
    end
    hold_nxt = (st_nxt != S_IDLE);
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      hwr_r <= 1'b0;
      hidx_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      refdiv_r <= REFDIV_RST;
      int_r <= INT_RST;
      frac_r <= FRAC_RST;
      fwd_r <= FWD_RST;
      relock_en_r <= 1'b0;
      calcfg_r <= CALCFG_RST;
      err_r <= '0;
      skip_r <= 1'b0;
      st_r <= S_IDLE;
      cdiv_r <= 6'h00;
      sw_r <= '0;
      bit_r <= '0;
      wait_r <= 9'h000;
      win_r <= 22'h000000;
      cnt_r <= '0;
      relock_used_r <= 1'b0;
      lock_d_r <= 1'b0;
      sh_r <= 16'h0000;
      bc_r <= 5'h00;
      xfer_r <= 1'b0;
      sen_n_r <= 1'b1;
      sck_r <= 1'b0;
      sck_arm_r <= 1'b0;
      resend_r <= 1'b0;
      sdo_r <= 1'b0;
      hold_r <= 1'b0;
      load_r <= 1'b0;
      mint_r <= INT_RST;
      mfrac_r <= FRAC_RST;
      odiv_r <= OUTDIV_RST;
    end
    else
    begin
      hwr_r <= hwr_nxt;
      hidx_r <= hidx_nxt;
      hrdata_r <= hrdata_nxt;
      refdiv_r <= refdiv_nxt;
      int_r <= int_nxt;
      frac_r <= frac_nxt;
      fwd_r <= fwd_nxt;
      relock_en_r <= relock_en_nxt;
      calcfg_r <= calcfg_nxt;
      err_r <= err_nxt;
      skip_r <= skip_nxt;
      st_r <= st_nxt;
      cdiv_r <= cdiv_nxt;
      sw_r <= sw_nxt;
      bit_r <= bit_nxt;
      wait_r <= wait_nxt;
      win_r <= win_nxt;
      cnt_r <= cnt_nxt;
      relock_used_r <= relock_used_nxt;
      lock_d_r <= lock_d_nxt;
      sh_r <= sh_nxt;
      bc_r <= bc_nxt;
      xfer_r <= xfer_nxt;
      sen_n_r <= sen_n_nxt;
      sck_r <= sck_nxt;
      sck_arm_r <= sck_arm_nxt;
      resend_r <= resend_nxt;
      sdo_r <= sdo_nxt;
      hold_r <= hold_nxt;
      load_r <= load_nxt;
      mint_r <= mint_nxt;
      mfrac_r <= mfrac_nxt;
      odiv_r <= odiv_nxt;
    end
  end

  assign HREADYOUT_O = RST_N_I | 1'b1;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = hrdata_r;
  assign VSL_SEN_N_O = sen_n_r;
  assign VSL_SCK_O = sck_r;
  assign VSL_SDO_O = sdo_r;
  assign VTUNE_HOLD_O = hold_r;
  assign MOD_LOAD_O = load_r;
  assign MOD_INT_O = mint_r;
  assign MOD_FRAC_O = mfrac_r;
  assign OUT_DIV_O = odiv_r;
  assign CAL_BUSY_O = hold_r;

endmodule
`default_nettype wire

// ==== sim/vco_cal_fsm_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module vco_cal_fsm_chk (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic VSL_SEN_N_O,
  input wire logic VSL_SCK_O,
  input wire logic VSL_SDO_O,
  input wire logic VTUNE_HOLD_O,
  input wire logic MOD_LOAD_O,
  input wire logic [18:0] MOD_INT_O,
  input wire logic [5:0] OUT_DIV_O,
  input wire logic CAL_BUSY_O
);
  logic [4:0] sck_cnt_r, sck_cnt_nxt;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  always_comb
  begin
    sck_cnt_nxt = sck_cnt_r;
    if (VSL_SEN_N_O)
      sck_cnt_nxt = 5'h00;
    else if (VSL_SCK_O)
      sck_cnt_nxt = sck_cnt_r + 5'h01;
  end
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      sck_cnt_r <= 5'h00;
    else
      sck_cnt_r <= sck_cnt_nxt;
  end
  sequence load_near;
    ##[0:2] MOD_LOAD_O;
  endsequence
  ready_okay_a: assert property (HREADYOUT_O && !HRESP_O)
    else $error("bus slave not ready or not okay");
  hold_busy_a: assert property (VTUNE_HOLD_O == CAL_BUSY_O)
    else $error("tuning hold differs from busy");
  load_pulse_a: assert property (MOD_LOAD_O |=> !MOD_LOAD_O)
    else $error("divider load longer than one cycle");
  div_load_a: assert property ($changed(MOD_INT_O) |-> MOD_LOAD_O)
    else $error("divider changed without load");
  cal_load_a: assert property ($fell(CAL_BUSY_O) |-> load_near or $past(MOD_LOAD_O))
    else $error("calibration ended without divider load");
  sck_frame_a: assert property (VSL_SCK_O |-> !VSL_SEN_N_O && $stable(VSL_SDO_O))
    else $error("serial clock outside frame or data moving");
  frame_bits_a: assert property ($rose(VSL_SEN_N_O) |-> sck_cnt_r == 5'h10)
    else $error("serial frame without sixteen bits");
  out_div_a: assert property (OUT_DIV_O == 6'h01 || (!OUT_DIV_O[0] && OUT_DIV_O != 6'h00
    && OUT_DIV_O <= 6'h3e))
    else $error("illegal output divide");
endmodule
bind vco_cal_fsm vco_cal_fsm_chk chk_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .VSL_SEN_N_O(VSL_SEN_N_O),
  .VSL_SCK_O(VSL_SCK_O), .VSL_SDO_O(VSL_SDO_O), .VTUNE_HOLD_O(VTUNE_HOLD_O),
  .MOD_LOAD_O(MOD_LOAD_O), .MOD_INT_O(MOD_INT_O), .OUT_DIV_O(OUT_DIV_O),
  .CAL_BUSY_O(CAL_BUSY_O));
`default_nettype wire

// ==== sim/vco_side_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module vco_side_model #(
  parameter int REF_PER = 48,
  parameter int RATE_TOP = 40
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sen_n_i,
  input wire logic sck_i,
  input wire logic sdo_i,
  output logic ref_tick_o,
  output logic vco_tick_o,
  output logic [15:0] word_o,
  output logic [7:0] n_words_o
);
  logic [15:0] sh;
  logic [4:0] sw;
  logic sen_q;
  int ph;
  // higher switch setting runs slower; ticks kept clear of window edges
  assign ref_tick_o = (ph == 0);
  assign vco_tick_o = (ph >= 4) && (ph < 4 + RATE_TOP - int'(sw));
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ph <= 0;
      sh <= 16'h0000;
      sw <= 5'h00;
      sen_q <= 1'b1;
      word_o <= 16'h0000;
      n_words_o <= 8'h00;
    end
    else
    begin
      ph <= (ph == REF_PER - 1) ? 0 : ph + 1;
      sen_q <= sen_n_i;
      if (!sen_n_i && sck_i)
        sh <= {sh[14:0], sdo_i};
      if (sen_n_i && !sen_q)
      begin
        word_o <= sh;
        n_words_o <= n_words_o + 8'h01;
        if (sh[6:0] == 7'h00)
          sw <= sh[12:8];
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/vco_cal_fsm_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module vco_cal_fsm_tb;
  import vco_cal_pkg::*;
  logic clk, rst_n, hsel, hwrite, lock, rdy, ld, sen_n, sck, sdo, busy, rtick, vtick;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [18:0] mint;
  logic [23:0] mfrac;
  logic [5:0] odiv;
  logic [15:0] lw;
  logic [7:0] nw, w;
  int n_errors, samples_checked, cyc;
  vco_cal_fsm dut (.CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(rdy),
    .HREADYOUT_O(rdy), .HRDATA_O(hrdata), .HRESP_O(), .REF_TICK_I(rtick), .VCO_TICK_I(vtick),
    .LOCK_I(lock), .VSL_SEN_N_O(sen_n), .VSL_SCK_O(sck), .VSL_SDO_O(sdo), .VTUNE_HOLD_O(),
    .MOD_LOAD_O(ld), .MOD_INT_O(mint), .MOD_FRAC_O(mfrac), .OUT_DIV_O(odiv), .CAL_BUSY_O(busy));
  vco_side_model vm (.clk_i(clk), .rst_n_i(rst_n), .sen_n_i(sen_n), .sck_i(sck),
    .sdo_i(sdo), .ref_tick_o(rtick), .vco_tick_o(vtick), .word_o(lw), .n_words_o(nw));
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_ld(input int lim);
    int i;
    i = 0;
    while (ld !== 1'b1 && i < lim)
    begin
      @(posedge clk);
      i++;
    end
    chk({31'h0, ld}, 32'h1);
  endtask
  task automatic wait_w(input logic [7:0] n);
    int i;
    i = 0;
    while (nw !== n && i < 3000)
    begin
      @(posedge clk);
      i++;
    end
    chk({24'h0, nw}, {24'h0, n});
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    cyc = 0;
    forever
    begin
      @(posedge clk);
      cyc++;
      if (cyc == 90000)
      begin
        n_errors++;
        complete_run();
      end
    end
  end
  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    lock = 1'b1;
    n_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk({26'h0, odiv}, 32'h1);
    bus(1'b0, IDX_REFDIV, 32'h0);
    chk(rd, 32'h1);
    bus(1'b1, 8'h3f, 32'hffff_ffff);
    bus(1'b0, 8'h3f, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, IDX_FWD, 32'h7f10);
    wait_w(8'h01);
    chk({16'h0, lw}, 32'h7f10);
    chk({26'h0, odiv}, 32'h3e);
    bus(1'b1, IDX_FWD, 32'h0);
    wait_w(8'h02);
    w = nw;
    bus(1'b1, IDX_INT, 32'h1e);
    wait_ld(20000);
    chk({13'h0, mint}, 32'h1e);
    chk({24'h0, nw - w}, 32'h6);
    chk({16'h0, lw}, 32'h2900);
    bus(1'b0, IDX_SWSTAT, 32'h0);
    chk(rd, 32'h29);
    bus(1'b1, IDX_CALCFG, 32'h2003);
    bus(1'b1, IDX_FRAC, 32'h80_0000);
    wait_ld(30000);
    chk({8'h0, mfrac}, 32'h80_0000);
    bus(1'b0, IDX_CNTERR, 32'h0);
    chk(rd, 32'h4);
    bus(1'b1, IDX_CALCFG, 32'h4);
    bus(1'b1, IDX_FRAC, 32'h80_0000);
    wait_ld(20000);
    bus(1'b0, IDX_CNTERR, 32'h0);
    chk(rd, 32'h10);
    bus(1'b1, IDX_CALCFG, 32'h0);
    bus(1'b1, IDX_INT, 32'h1e);
    repeat (300) @(posedge clk);
    bus(1'b1, IDX_INT, 32'h14);
    wait_ld(20000);
    chk({13'h0, mint}, 32'h14);
    bus(1'b0, IDX_SWSTAT, 32'h0);
    chk(rd, 32'h33);
    bus(1'b1, IDX_LDCFG, 32'h2000);
    @(posedge clk);
    lock <= 1'b0;
    wait_ld(20000);
    @(posedge clk);
    lock <= 1'b1;
    repeat (5) @(posedge clk);
    lock <= 1'b0;
    repeat (200) @(posedge clk);
    chk({31'h0, busy}, 32'h0);
    bus(1'b1, IDX_CALCFG, 32'h800);
    bus(1'b1, IDX_INT, 32'h19);
    wait_ld(8);
    chk({13'h0, mint}, 32'h19);
    bus(1'b1, IDX_CALCFG, 32'h0);
    bus(1'b1, IDX_FWD, 32'h2901);
    bus(1'b1, IDX_INT, 32'h1a);
    wait_ld(8);
    bus(1'b0, IDX_SWSTAT, 32'h0);
    chk(rd & 32'h200, 32'h200);
    complete_run();
  end
endmodule
`default_nettype wire
